/* common/fsp_pkg.sv */
// package of constants for the flash status and protection register bank
package fsp_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_INSTR    = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_INSTR    = 8'h04;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_RDFR    = 8'h48;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_PPQ_A   = 8'h32;
  localparam logic [7:0] OP_PPQ_B   = 8'h38;
  localparam logic [7:0] OP_SE_A    = 8'hd7;
  localparam logic [7:0] OP_SE_B    = 8'h20;
  localparam logic [7:0] OP_HBE     = 8'h52;
  localparam logic [7:0] OP_FBE     = 8'hd8;
  localparam logic [7:0] OP_CE_A    = 8'hc7;
  localparam logic [7:0] OP_CE_B    = 8'h60;
  localparam logic [7:0] OP_WSTAT   = 8'h01;
  localparam logic [7:0] OP_WFUNC   = 8'h42;
  localparam logic [7:0] OP_NVRP    = 8'h65;
  localparam logic [7:0] OP_NVERP   = 8'h85;
  localparam logic [7:0] OP_VRP_A   = 8'hc0;
  localparam logic [7:0] OP_VRP_B   = 8'h63;
  localparam logic [7:0] OP_VERP    = 8'h83;
  localparam logic [7:0] OP_ABW     = 8'h15;
  localparam logic [7:0] OP_INFO_ROW_ERASE    = 8'h64;
  localparam logic [7:0] OP_IRPG    = 8'h62;
  localparam logic [7:0] OP_SUSP    = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_RSTEN   = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  // status bit positions
  localparam int SR_BUSY = 0;
  localparam int SR_WEL  = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_QE   = 6;
  localparam int SR_SWD  = 7;
  // function bit positions
  localparam int FR_RSTDIS = 0;
  localparam int FR_PROGRAM_SUSPENDED_FLAG   = 2;
  localparam int FR_ERASE_SUSPENDED_FLAG   = 3;
  localparam int FR_IRL_LO = 4;
  // reset values
  localparam logic [7:0] SR_RESET  = 8'h00;
  localparam logic [3:0] IRL_RESET = 4'h0;
  localparam logic [7:0] RP_RESET  = 8'h00;
  // block geometry: 32 blocks, block number is addr[20:16]
  localparam int BLK_LSB = 16;
  localparam int BLK_W   = 5;
  localparam logic [4:0] BLK_TOP = 5'h1f;
  // frame phases
  typedef enum logic [2:0]
  {
    FSP_IDLE = 3'b000,
    FSP_OPC  = 3'b001,
    FSP_ARG  = 3'b011,
    FSP_DONE = 3'b010,
    FSP_SKIP = 3'b110
  } fsp_state_t;
endpackage : fsp_pkg

/* verilog/fsp_regs.sv */
// status, function and read-parameter register bank of a serial nor flash
`timescale 1ns/1ps
// Contract
// - write-class opcodes are refused while the latch is clear
// - latch set by enable, cleared by disable and at write completion
// - volatile parameter writes run without the latch
// - page program opcodes are latch gated
// - sector, block and chip erase opcodes are latch gated
// - register writing opcodes are latch gated
// - info row erase and program are latch gated
// - program or erase into a protected block is blocked
// - codes 1 to 5 guard top blocks, 6 to 9 all, 0 and 15 none
// - codes 10 to 14 guard bottom 16 down to 1 blocks
// - chip erase ignored unless protect code is zero
// - status write ignored when disable bit set, protect pin low and quad enable clear
// - status write allowed otherwise
// - quad enable turns protect and hold pins into data lines
// - function register bit layout fixed
// - one-time bits never return to zero
// - reset-disable bit moves reset to hold pin, writable while zero
// - program suspend flag set on suspend, cleared on resume
// - erase suspend flag set on suspend, cleared on resume
// - lock bit set refuses program of its info row
// - while busy only reads, suspend and resume are obeyed; the reset opcodes are not decoded at all
// - status write clears the latch
// - volatile parameter copies load from nonvolatile at power up
module fsp_regs
  import fsp_pkg::*;
#(
  parameter logic RSTDIS_DEFAULT = 1'b0
)
(
  input  wire logic       clk_sys_in,
  input  wire logic       arst_n_in,
  input  wire logic       clk_en_in,
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  input  wire logic       si_in,
  input  wire logic       wp_n_in,
  input  wire logic       op_done_in,
  output logic            so_out,
  output logic            so_oe_n_out,
  output logic [7:0]      status_out,
  output logic [7:0]      func_out,
  output logic [7:0]      vread_param_out,
  output logic [7:0]      vext_param_out,
  output logic            op_start_out,
  output logic [7:0]      op_code_out,
  output logic [23:0]     op_addr_out,
  output logic            wp_pin_active_out,
  output logic            hold_reset_on_shared_out
);
  // two-stage synchronisers for pin inputs
  logic [1:0] cs_s_r, sck_s_r, si_s_r, wp_s_r;
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      cs_s_r  <= 2'h3;
      sck_s_r <= 2'h0;
      si_s_r  <= 2'h0;
      wp_s_r  <= 2'h3;
    end
    else if (clk_en_in)
    begin
      cs_s_r  <= {cs_s_r[0], cs_n_in};
      sck_s_r <= {sck_s_r[0], sck_in};
      si_s_r  <= {si_s_r[0], si_in};
      wp_s_r  <= {wp_s_r[0], wp_n_in};
    end

  logic sck_d_r;
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
      sck_d_r <= 1'b0;
    else if (clk_en_in)
      sck_d_r <= sck_s_r[1];
  wire logic sck_rise = sck_s_r[1] & ~sck_d_r;
  wire logic sck_fall = ~sck_s_r[1] & sck_d_r;
  wire logic cs_act   = ~cs_s_r[1];

  // registers
  logic [7:0] sr_r;
  logic [3:0] irl_r;
  logic       rstdis_r;
  logic [7:0] nvrp_r, nverp_r, vrp_r, verp_r;
  logic       nv_load_r;
  logic       susp_prog_r, susp_erase_r;
  logic       is_erase_r;
  // function read view; one driver per bit group, reserved bit 1 reads zero
  wire logic [7:0] fr_r = {irl_r, susp_erase_r, susp_prog_r, 1'b0, rstdis_r};

  // protect decode
  wire logic [3:0] bp = sr_r[SR_BP_LO +: 4];
  function automatic logic blk_prot(input logic [3:0] c, input logic [4:0] b);
    logic r;
    r = 1'b0;
    case (c)
      4'h1: r = (b == BLK_TOP);
      4'h2: r = (b >= 5'h1e);
      4'h3: r = (b >= 5'h1c);
      4'h4: r = (b >= 5'h18);
      4'h5: r = (b >= 5'h10);
      4'h6, 4'h7, 4'h8, 4'h9: r = 1'b1;
      4'ha: r = (b <= 5'h0f);
      4'hb: r = (b <= 5'h07);
      4'hc: r = (b <= 5'h03);
      4'hd: r = (b <= 5'h01);
      4'he: r = (b == 5'h00);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : blk_prot

  // frame shifter: mode 0 spi, sample on rise
  fsp_state_t st_r;
  logic [2:0]  bit_r;
  logic [7:0]  shf_r;
  logic [7:0]  opc_r;
  logic [1:0]  byt_r;
  logic [23:0] adr_r;
  logic [7:0]  dat_r;
  logic        have_dat_r;
  logic        rst_arm_r;
  wire logic [7:0] shf_nxt = {shf_r[6:0], si_s_r[1]};
  wire logic byte_in = sck_rise && (bit_r == 3'h7);

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      st_r <= FSP_IDLE;
      bit_r <= 3'h0;
      shf_r <= 8'h00;
      opc_r <= 8'h00;
      byt_r <= 2'h0;
      adr_r <= 24'h000000;
      dat_r <= 8'h00;
      have_dat_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!cs_act)
      begin
        st_r <= (st_r == FSP_IDLE) ? FSP_IDLE : FSP_DONE;
        bit_r <= 3'h0;
        if (st_r == FSP_DONE || st_r == FSP_SKIP)
          st_r <= FSP_IDLE;
      end
      else if (sck_rise)
      begin
        shf_r <= shf_nxt;
        bit_r <= bit_r + 3'h1;
        case (st_r)
          FSP_IDLE, FSP_OPC:
          begin
            st_r <= FSP_OPC;
            have_dat_r <= 1'b0;
            byt_r <= 2'h0;
            if (byte_in)
            begin
              opc_r <= shf_nxt;
              st_r <= FSP_ARG;
            end
          end
          FSP_ARG:
            if (byte_in)
            begin
              if (byt_r < 2'h3)
                adr_r <= {adr_r[15:0], shf_nxt};
              dat_r <= shf_nxt;
              have_dat_r <= 1'b1;
              if (byt_r != 2'h3)
                byt_r <= byt_r + 2'h1;
            end
          default: ;
        endcase
      end
    end

  // frame end pulse: cs released after an opcode
  wire logic frame_end = !cs_act && (st_r == FSP_ARG);
  wire logic busy = sr_r[SR_BUSY];
  wire logic write_enable_latch  = sr_r[SR_WEL];
  wire logic [4:0] blk = adr_r[BLK_LSB +: BLK_W];
  wire logic is_prog  = (opc_r == OP_PP) || (opc_r == OP_PPQ_A) || (opc_r == OP_PPQ_B);
  wire logic is_ers   = (opc_r == OP_SE_A) || (opc_r == OP_SE_B) || (opc_r == OP_HBE)
                        || (opc_r == OP_FBE);
  wire logic is_ce    = (opc_r == OP_CE_A) || (opc_r == OP_CE_B);
  wire logic is_ir    = (opc_r == OP_INFO_ROW_ERASE) || (opc_r == OP_IRPG);
  wire logic is_regw  = (opc_r == OP_WSTAT) || (opc_r == OP_WFUNC) || (opc_r == OP_NVRP)
                        || (opc_r == OP_NVERP) || (opc_r == OP_ABW);
  wire logic gated    = is_prog | is_ers | is_ce | is_ir | is_regw;
  // info row index from address bits 13:12 of the row address
  wire logic [1:0] irow = adr_r[13:12];
  wire logic ir_locked = (opc_r == OP_IRPG) && fr_r[FR_IRL_LO + irow];
  wire logic prot_hit  = ((is_prog | is_ers) && blk_prot(bp, blk))
                         || (is_ce && (bp != 4'h0));
  wire logic sr_locked = sr_r[SR_SWD] && !wp_s_r[1] && !sr_r[SR_QE];
  wire logic accept    = frame_end && !busy && (!gated || write_enable_latch);
  wire logic launch    = accept && (is_prog | is_ers | is_ce | is_ir) && !prot_hit && !ir_locked;

  // status register
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
      sr_r <= SR_RESET;
    else if (clk_en_in)
    begin
      if (busy && op_done_in)
      begin
        sr_r[SR_BUSY] <= 1'b0;
        sr_r[SR_WEL]  <= 1'b0;
      end
      if (frame_end && !busy)
      begin
        if (opc_r == OP_WRITE_ENABLE_INSTR)
          sr_r[SR_WEL] <= 1'b1;
        if (opc_r == OP_WRITE_DISABLE_INSTR)
          sr_r[SR_WEL] <= 1'b0;
        if (accept && gated && !launch)
          sr_r[SR_WEL] <= 1'b0;
        if (accept && opc_r == OP_WSTAT && have_dat_r && !sr_locked)
          sr_r[7:2] <= dat_r[7:2];
        if (launch)
          sr_r[SR_BUSY] <= 1'b1;
      end
    end

  // function register, one-time bits only rise
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      irl_r    <= IRL_RESET;
      rstdis_r <= RSTDIS_DEFAULT;
    end
    else if (clk_en_in)
    begin
      // written bits 3:1 are read only and simply not stored
      if (accept && opc_r == OP_WFUNC && have_dat_r)
      begin
        irl_r    <= irl_r | dat_r[7:4];
        rstdis_r <= rstdis_r | dat_r[0];
      end
    end

  // suspend and resume
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      susp_prog_r <= 1'b0;
      susp_erase_r <= 1'b0;
      is_erase_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (launch)
        is_erase_r <= is_ers | is_ce | (opc_r == OP_INFO_ROW_ERASE);
      if (frame_end && busy && opc_r == OP_SUSP)
      begin
        susp_prog_r  <= !is_erase_r;
        susp_erase_r <= is_erase_r;
      end
      if (frame_end && opc_r == OP_RESUME)
      begin
        susp_prog_r  <= 1'b0;
        susp_erase_r <= 1'b0;
      end
    end

  // read parameter pairs; volatile set loads from nonvolatile at reset
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      nvrp_r <= RP_RESET;
      nverp_r <= RP_RESET;
      vrp_r <= RP_RESET;
      verp_r <= RP_RESET;
      nv_load_r <= 1'b1;
    end
    else if (clk_en_in)
    begin
      // first enabled cycle after reset copies the stored set into the live one
      if (nv_load_r)
      begin
        vrp_r <= nvrp_r;
        verp_r <= nverp_r;
      end
      nv_load_r <= 1'b0;
      if (accept && have_dat_r)
      begin
        if (opc_r == OP_NVRP)
        begin
          nvrp_r <= dat_r;
          vrp_r <= dat_r;
        end
        if (opc_r == OP_NVERP)
        begin
          nverp_r <= dat_r;
          verp_r <= dat_r;
        end
        if (opc_r == OP_VRP_A || opc_r == OP_VRP_B)
          vrp_r <= dat_r;
        if (opc_r == OP_VERP)
          verp_r <= dat_r;
      end
    end

  // readback on falling sck
  logic [7:0] rd_r;
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      rd_r <= 8'h00;
      so_out <= 1'b0;
      so_oe_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (!cs_act)
        so_oe_n_out <= 1'b1;
      else if (sck_fall && st_r == FSP_ARG)
      begin
        if (bit_r == 3'h0)
        begin
          so_out <= (opc_r == OP_RDFR) ? fr_r[7] : sr_r[7];
          rd_r <= (opc_r == OP_RDFR) ? {fr_r[6:0], 1'b0} : {sr_r[6:0], 1'b0};
        end
        else
        begin
          so_out <= rd_r[7];
          rd_r <= {rd_r[6:0], 1'b0};
        end
        so_oe_n_out <= !(opc_r == OP_RDSR || opc_r == OP_RDFR);
      end
    end

  // registered views and operation launch
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      status_out <= 8'h00;
      func_out <= 8'h00;
      vread_param_out <= 8'h00;
      vext_param_out <= 8'h00;
      op_start_out <= 1'b0;
      op_code_out <= 8'h00;
      op_addr_out <= 24'h000000;
      wp_pin_active_out <= 1'b1;
      hold_reset_on_shared_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      status_out <= sr_r;
      func_out <= fr_r;
      vread_param_out <= vrp_r;
      vext_param_out <= verp_r;
      op_start_out <= launch;
      if (launch)
      begin
        op_code_out <= opc_r;
        op_addr_out <= adr_r;
      end
      wp_pin_active_out <= !sr_r[SR_QE];
      hold_reset_on_shared_out <= fr_r[FR_RSTDIS] && !sr_r[SR_QE];
    end

  // a gated opcode without the latch never starts an operation
  a_latch_gate: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    launch |-> write_enable_latch) else $error("operation launched without latch");
  // a protected target never starts
  a_prot_block: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (frame_end && prot_hit) |-> !launch) else $error("protected target launched");
  // chip erase needs code zero
  a_chip_erase: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (launch && is_ce) |-> (bp == 4'h0)) else $error("chip erase under protection");
  // latch cleared one cycle after completion
  a_wel_clear: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (clk_en_in && busy && op_done_in) |=> !write_enable_latch) else $error("latch not cleared");
  // locked status stays fixed over a write
  a_sr_lock: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (clk_en_in && sr_locked && !busy) |=> $stable(sr_r[7:2])) else $error("locked status changed");
  // one-time bits never fall
  a_otp_keep: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $past(fr_r[7:4]) == ($past(fr_r[7:4]) & fr_r[7:4])) else $error("otp bit fell");
  // locked row refuses program
  a_irow_lock: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (frame_end && ir_locked) |-> !launch) else $error("locked row programmed");
  // busy refuses new operations
  a_busy_ignore: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    busy |-> !launch) else $error("launch while busy");
  // suspend flags exclusive
  a_susp_excl: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !(susp_prog_r && susp_erase_r)) else $error("both suspend flags set");
  // quad enable steers pin role
  a_quad_pins: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (clk_en_in && $stable(sr_r[SR_QE])) |=> (wp_pin_active_out == !$past(sr_r[SR_QE])))
    else $error("pin role wrong");
endmodule : fsp_regs

/* verif/fsp_host_model.sv */
// host controller model that frames instructions on the serial pins
`timescale 1ns/1ps
module fsp_host_model
(
  input  wire logic clk_sys_in,
  input  wire logic so_in,
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out
);
  // last eight bits seen on the data-out line, sampled at each sck rise
  logic [7:0] rd_sh = 8'h00;

  // idle: deselected with the clock parked low, as mode 0 wants
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
  end

  // every pin change lands 2 ns after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask : tick

  // sends nbytes msb first from the top of bits; sck runs at 400 ns
  task automatic frame(input logic [31:0] bits, input int nbytes);
    int i;
    tick(1);
    cs_n_out = 1'b0;
    tick(4);
    for (i = 31; i > 31 - 8 * nbytes; i--)
    begin
      si_out = bits[i];
      tick(4);
      rd_sh = {rd_sh[6:0], so_in};
      sck_out = 1'b1;
      tick(4);
      sck_out = 1'b0;
    end
    tick(4);
    // a released line holds no valid level, so show the inverse
    si_out = ~si_out;
    cs_n_out = 1'b1;
    // gap far above the 4-cycle minimum so the frame has executed
    tick(12);
  endtask : frame
endmodule : fsp_host_model

/* verif/tb_fsp_regs.sv */
// self-checking bench for the flash status and protection register bank
`timescale 1ns/1ps
module tb_fsp_regs;
  import fsp_pkg::*;
  localparam logic [7:0] GATED [11] = '{OP_PP, OP_PPQ_A, OP_PPQ_B, OP_SE_A, OP_SE_B, OP_HBE,
                                        OP_FBE, OP_CE_A, OP_CE_B, OP_INFO_ROW_ERASE, OP_IRPG};
  localparam logic [4:0] BLKS [4] = '{5'h00, 5'h0f, 5'h10, 5'h1f};
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        clk_en_in = 1'b1;
  logic        wp_n_in = 1'b1;
  logic        op_done_in = 1'b0;
  wire         cs_n;
  wire         sck;
  wire         si;
  logic        so_out;
  logic        so_oe_n_out;
  logic [7:0]  status_out;
  logic [7:0]  func_out;
  logic [7:0]  vread_param_out;
  logic [7:0]  vext_param_out;
  logic        op_start_out;
  logic [7:0]  op_code_out;
  logic [23:0] op_addr_out;
  logic        wp_pin_active_out;
  logic        hold_reset_on_shared_out;
  int          err_count = 0;
  int          cmp_count = 0;
  int          starts = 0;
  int          cycles = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  // an undriven data line shows the inverse of the last bit
  fsp_host_model host (.clk_sys_in(clk_sys_in), .so_in(so_oe_n_out ? ~so_out : so_out),
    .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

  fsp_regs uut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
    .cs_n_in(cs_n), .sck_in(sck), .si_in(si), .wp_n_in(wp_n_in), .op_done_in(op_done_in),
    .so_out(so_out), .so_oe_n_out(so_oe_n_out), .status_out(status_out),
    .func_out(func_out), .vread_param_out(vread_param_out),
    .vext_param_out(vext_param_out), .op_start_out(op_start_out),
    .op_code_out(op_code_out), .op_addr_out(op_addr_out),
    .wp_pin_active_out(wp_pin_active_out),
    .hold_reset_on_shared_out(hold_reset_on_shared_out));

  // launches are counted here so a pulse is never missed between frames
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (op_start_out === 1'b1)
      starts++;
    if (cycles == 90000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] op);
    host.frame({op, 24'h000000}, 1);
  endtask : cmd

  // register write, data byte straight after the opcode
  task automatic wr(input logic [7:0] op, input logic [7:0] d, input logic en);
    if (en)
      cmd(OP_WRITE_ENABLE_INSTR);
    host.frame({op, d, 16'h0000}, 2);
  endtask : wr

  // register read: opcode, then one byte shifted back on the data line
  task automatic rd(input string what, input logic [7:0] op, input logic [7:0] exp);
    host.frame({op, 24'h000000}, 2);
    chk(what, exp, host.rd_sh);
  endtask : rd

  task automatic done_pulse();
    host.tick(1);
    op_done_in = 1'b1;
    host.tick(1);
    op_done_in = 1'b0;
    host.tick(4);
  endtask : done_pulse

  // addressed instruction; exp says whether it must launch
  task automatic launch(input logic [7:0] op, input logic [23:0] a, input logic exp,
                        input logic fin);
    int s0;
    s0 = starts;
    host.frame({op, a}, 4);
    chk("launches", {7'h00, exp}, 8'(starts - s0));
    if (exp)
    begin
      chk("op code", op, op_code_out);
      chk("busy", 8'h01, {7'h00, status_out[SR_BUSY]});
    end
    if (fin && exp)
      done_pulse();
    if (fin)
      chk("busy and latch", 8'h00, {6'h00, status_out[1:0]});
  endtask : launch

  function automatic logic prot(input logic [3:0] c, input logic [4:0] b);
    if (c >= 4'h1 && c <= 4'h5)
      return b >= 5'(32 - (1 << (c - 1)));
    if (c >= 4'h6 && c <= 4'h9)
      return 1'b1;
    if (c >= 4'ha && c <= 4'he)
      return b < 5'(16 >> (c - 10));
    return 1'b0;
  endfunction : prot

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // wp_n is always driven, never tied to the supply, so quad enable may be set
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    #2;
    arst_n_in = 1'b1;
    host.tick(4);
    chk("status", SR_RESET, status_out);
    chk("function", 8'h00, func_out);
    chk("volatile read", RP_RESET, vread_param_out);
    chk("volatile ext", RP_RESET, vext_param_out);
    chk("pin roles", 8'h03, {6'h00, so_oe_n_out, wp_pin_active_out});
    $display("test reset done");
    // gated opcodes: refused without the latch, launched right after it
    foreach (GATED[i])
    begin
      launch(GATED[i], 24'h000000, 1'b0, 1'b1);
      cmd(OP_WRITE_ENABLE_INSTR);
      chk("latch set", 8'h02, status_out);
      launch(GATED[i], 24'h000000, 1'b1, 1'b1);
    end
    cmd(OP_WRITE_ENABLE_INSTR);
    cmd(OP_WRITE_DISABLE_INSTR);
    chk("latch cleared", 8'h00, status_out);
    // a frame sent while the clock enable is low is never seen
    clk_en_in = 1'b0;
    cmd(OP_WRITE_ENABLE_INSTR);
    clk_en_in = 1'b1;
    host.tick(4);
    chk("frozen latch", 8'h00, status_out);
    wr(OP_WSTAT, 8'h3c, 1'b0);
    chk("status", 8'h00, status_out);
    wr(OP_WFUNC, 8'h10, 1'b0);
    chk("function", 8'h00, func_out);
    $display("test latch done");
    wr(OP_VRP_A, 8'ha5, 1'b0);
    chk("volatile read", 8'ha5, vread_param_out);
    wr(OP_VRP_B, 8'h5a, 1'b0);
    chk("volatile read", 8'h5a, vread_param_out);
    wr(OP_VERP, 8'h3c, 1'b0);
    chk("volatile ext", 8'h3c, vext_param_out);
    wr(OP_NVRP, 8'h33, 1'b0);
    chk("volatile read", 8'h5a, vread_param_out);
    wr(OP_NVERP, 8'hc3, 1'b1);
    chk("status", 8'h00, status_out);
    wr(OP_ABW, 8'h01, 1'b1);
    chk("status", 8'h00, status_out);
    $display("test volatile done");
    // erase suspended then resumed, with a program refused while busy
    cmd(OP_WRITE_ENABLE_INSTR);
    launch(OP_SE_B, 24'h000000, 1'b1, 1'b0);
    rd("status read", OP_RDSR, 8'h03);
    launch(OP_PP, 24'h000100, 1'b0, 1'b0);
    cmd(OP_SUSP);
    chk("suspend flags", 8'h02, {6'h00, func_out[FR_ERASE_SUSPENDED_FLAG], func_out[FR_PROGRAM_SUSPENDED_FLAG]});
    rd("function read", OP_RDFR, 8'h08);
    cmd(OP_RESUME);
    chk("suspend flags", 8'h00, {6'h00, func_out[FR_ERASE_SUSPENDED_FLAG], func_out[FR_PROGRAM_SUSPENDED_FLAG]});
    done_pulse();
    cmd(OP_WRITE_ENABLE_INSTR);
    launch(OP_PP, 24'h000100, 1'b1, 1'b0);
    cmd(OP_SUSP);
    chk("suspend flags", 8'h01, {6'h00, func_out[FR_ERASE_SUSPENDED_FLAG], func_out[FR_PROGRAM_SUSPENDED_FLAG]});
    cmd(OP_RESUME);
    chk("suspend flags", 8'h00, {6'h00, func_out[FR_ERASE_SUSPENDED_FLAG], func_out[FR_PROGRAM_SUSPENDED_FLAG]});
    done_pulse();
    chk("status", 8'h00, status_out);
    $display("test suspend done");
    // every protect code against edge blocks and a chip erase
    for (int c = 0; c < 16; c++)
    begin
      wr(OP_WSTAT, {2'b00, 4'(c), 2'b00}, 1'b1);
      chk("status", {2'b00, 4'(c), 2'b00}, status_out);
      foreach (BLKS[b])
      begin
        cmd(OP_WRITE_ENABLE_INSTR);
        launch(OP_SE_A, {3'b000, BLKS[b], 16'h0000}, !prot(4'(c), BLKS[b]), 1'b1);
      end
      cmd(OP_WRITE_ENABLE_INSTR);
      launch(OP_CE_B, 24'h000000, c == 0, 1'b1);
    end
    $display("test protect done");
    wr(OP_WSTAT, 8'h80, 1'b1);
    wp_n_in = 1'b0;
    wr(OP_WSTAT, 8'h84, 1'b1);
    chk("status", 8'h80, status_out);
    wp_n_in = 1'b1;
    wr(OP_WSTAT, 8'h42, 1'b1);
    chk("status", 8'h40, status_out);
    rd("status read", OP_RDSR, 8'h40);
    chk("protect pin role", 8'h00, {7'h00, wp_pin_active_out});
    wr(OP_WSTAT, 8'h00, 1'b1);
    chk("protect pin role", 8'h01, {7'h00, wp_pin_active_out});
    $display("test status lock done");
    wr(OP_WFUNC, 8'h1e, 1'b1);
    chk("function", 8'h10, func_out);
    wr(OP_WFUNC, 8'h00, 1'b1);
    chk("function", 8'h10, func_out);
    cmd(OP_WRITE_ENABLE_INSTR);
    launch(OP_IRPG, 24'h000000, 1'b0, 1'b1);
    cmd(OP_WRITE_ENABLE_INSTR);
    launch(OP_IRPG, 24'h001000, 1'b1, 1'b1);
    wr(OP_WFUNC, 8'h01, 1'b1);
    chk("function", 8'h11, func_out);
    chk("reset on shared pin", 8'h01, {7'h00, hold_reset_on_shared_out});
    rd("function read", OP_RDFR, 8'h11);
    $display("test function done");
    close_out();
  end
endmodule : tb_fsp_regs
